// ### design/flash_bus_pkg.sv
package flash_bus_pkg;

  // Bits in one transferred byte.
  localparam int unsigned BYTE_BITS = 8;

  // Number of flip-flops in every pin synchroniser.
  localparam int unsigned SYNC_STAGES = 2;

  // Period of the host serial clock in the bench, in nanoseconds.
  localparam int unsigned LINK_PERIOD_NS = 160;

  // Period of the block clock, in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 20;

  // Block clock cycles in one serial clock period.
  localparam int unsigned LINK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

  // Reset levels of the synchronised pins: select low, clock low, lines low.
  // Select resets low like its edge detector, so a select held low through
  // reset never looks like a fall; only a real rise and then a fall arms the port.
  localparam logic RST_CS_N = 1'b0;
  localparam logic RST_SCK  = 1'b0;
  localparam logic [3:0] RST_IO = 4'h0;

  // Output enable masks for each lane width.
  localparam logic [3:0] OE_NONE   = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL   = 4'h3;
  localparam logic [3:0] OE_QUAD   = 4'hF;

  // Lane width of a command phase, as chosen by the command decoder.
  typedef enum logic [1:0] {
    WIDTH_ONE  = 2'h0,
    WIDTH_TWO  = 2'h1,
    WIDTH_FOUR = 2'h2
  } lane_width_t;

  // Interface state, one-hot.
  typedef enum logic [3:0] {
    ST_UNARMED = 4'h1,
    ST_DESEL   = 4'h2,
    ST_ACTIVE  = 4'h4,
    ST_PAUSE   = 4'h8
  } bus_state_t;

  // Pin levels after synchronisation.
  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io;
  } pins_t;

  // Whole state of the front end.
  typedef struct packed {
    bus_state_t fsm;
    logic       sck_prev;
    logic       cs_n_prev;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] io_o;
    logic [3:0] io_oe;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       tx_req;
    logic       cmd_start;
    logic       cmd_end;
    logic       selected;
    logic       paused;
    logic       standby;
    logic       wp_n;
  } front_state_t;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/10ps

// Two-stage synchroniser for pins that come from outside the clock domain.
// The first stage is read only by the second, so metastability never leaks.
module pin_sync #(
  parameter int unsigned WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage, possibly metastable.
  logic [WIDTH-1:0] meta_q;

  // Both stages take the reset constant so the pins look idle after reset.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ### design/flash_bus_front.sv
`timescale 1ns/10ps

// Summary of operation
// - Single-bit commands: input on IO0, output IO1.
// - Output commands: address on IO0, data wide.
// - I/O commands: address and data both wide.
// - Capture input bits on serial clock rise.
// - Change output lines only after clock fall.
// - Chip select high: ignore inputs, float outputs.
// - Deselected: standby unless internal operation busy.
// - Chip select low selects, enters active power.
// - No command before first chip select fall.
// - One command spans one selected period.
// - Third pin: write protect, or IO2 quad.
// - Fourth pin: pause, or IO3 quad.
// - Select, protect and pause are active low.
// - Pause starts on pin low with clock low.
// - Paused: outputs float, clock and input ignored.
// - Four-bit enable disables write protect function.
module flash_bus_front (
  input  wire logic                      mclk_in,
  input  wire logic                      reset_in,
  input  wire logic                      sck_in,
  input  wire logic                      cs_n_in,
  input  wire logic [3:0]                io_in,
  output logic      [3:0]                io_out,
  output logic      [3:0]                io_oe_out,
  input  wire logic                      four_bit_enable_in,
  input  wire logic                      busy_in,
  input  wire flash_bus_pkg::lane_width_t rx_width_in,
  input  wire flash_bus_pkg::lane_width_t tx_width_in,
  input  wire logic                      tx_enable_in,
  input  wire logic [7:0]                tx_data_in,
  output logic      [7:0]                rx_byte_out,
  output logic                           rx_valid_out,
  output logic                           tx_req_out,
  output logic                           cmd_start_out,
  output logic                           cmd_end_out,
  output logic                           selected_out,
  output logic                           paused_out,
  output logic                           standby_out,
  output logic                           write_protect_n_out
);

  // Bits moved per serial clock edge for a lane width.
  function automatic logic [3:0] lane_bits(input flash_bus_pkg::lane_width_t w);
    unique case (w)
      flash_bus_pkg::WIDTH_TWO:  lane_bits = 4'h2;
      flash_bus_pkg::WIDTH_FOUR: lane_bits = 4'h4;
      default:                   lane_bits = 4'h1;
    endcase
  endfunction

  // Output enable mask for a lane width; single width drives IO1 only.
  function automatic logic [3:0] lane_oe(input flash_bus_pkg::lane_width_t w);
    unique case (w)
      flash_bus_pkg::WIDTH_TWO:  lane_oe = flash_bus_pkg::OE_DUAL;
      flash_bus_pkg::WIDTH_FOUR: lane_oe = flash_bus_pkg::OE_QUAD;
      default:                   lane_oe = flash_bus_pkg::OE_SINGLE;
    endcase
  endfunction

  // Synchronised pins; the serial clock travels with its data lines.
  flash_bus_pkg::pins_t pins_s;

  // Registered and next state.
  flash_bus_pkg::front_state_t st_q;
  flash_bus_pkg::front_state_t st_d;

  // Edge and mode terms derived from synchronised levels.
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic quad_op;
  logic hold_n;
  logic [7:0] tx_word;

  // All pins pass the same two stages, so data stays aligned with its clock edge.
  pin_sync #(
    .WIDTH     (6),
    .RESET_VAL ({flash_bus_pkg::RST_CS_N, flash_bus_pkg::RST_SCK, flash_bus_pkg::RST_IO})
  ) u_pin_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .async_in ({cs_n_in, sck_in, io_in}),
    .sync_out (pins_s)
  );

  // Edge detection compares the second stage with a third, held in the state.
  assign sck_rise = pins_s.sck & ~st_q.sck_prev;
  assign sck_fall = ~pins_s.sck & st_q.sck_prev;
  assign cs_fall  = ~pins_s.cs_n & st_q.cs_n_prev;
  assign cs_rise  = pins_s.cs_n & ~st_q.cs_n_prev;

  // Four-bit operation turns the upper pins into data lines.
  assign quad_op = four_bit_enable_in &
                   ((rx_width_in == flash_bus_pkg::WIDTH_FOUR) |
                    (tx_width_in == flash_bus_pkg::WIDTH_FOUR));

  // Pause input is active low and only meaningful outside four-bit operation.
  assign hold_n = quad_op | pins_s.io[3];

  // Next byte to shift out: a fresh one when the previous one is spent.
  assign tx_word = (st_q.tx_cnt == 4'h0) ? tx_data_in : st_q.tx_sh;

  // Next-state logic of the whole front end.
  always_comb
  begin
    st_d           = st_q;
    st_d.sck_prev  = pins_s.sck;
    st_d.cs_n_prev = pins_s.cs_n;
    st_d.rx_valid  = 1'b0;
    st_d.tx_req    = 1'b0;
    st_d.cmd_start = 1'b0;
    st_d.cmd_end   = 1'b0;
    // Protect input is disabled while four-bit operation is enabled.
    st_d.wp_n      = four_bit_enable_in | pins_s.io[2];
    unique case (st_q.fsm)
      // After reset nothing is accepted until select has been seen falling.
      flash_bus_pkg::ST_UNARMED:
      begin
        st_d.io_oe   = flash_bus_pkg::OE_NONE;
        st_d.standby = ~busy_in;
        if (cs_fall)
        begin
          st_d.fsm       = flash_bus_pkg::ST_ACTIVE;
          st_d.selected  = 1'b1;
          st_d.standby   = 1'b0;
          st_d.cmd_start = 1'b1;
          st_d.rx_cnt    = 4'h0;
          st_d.tx_cnt    = 4'h0;
        end
      end
      // Deselected: lines float and power drops once internal work ends.
      flash_bus_pkg::ST_DESEL:
      begin
        st_d.io_oe   = flash_bus_pkg::OE_NONE;
        st_d.standby = ~busy_in;
        if (cs_fall)
        begin
          st_d.fsm       = flash_bus_pkg::ST_ACTIVE;
          st_d.selected  = 1'b1;
          st_d.standby   = 1'b0;
          st_d.cmd_start = 1'b1;
          st_d.rx_cnt    = 4'h0;
          st_d.tx_cnt    = 4'h0;
        end
      end
      // Selected: shift bits in on rises and out on falls.
      flash_bus_pkg::ST_ACTIVE:
      begin
        if (pins_s.cs_n)
        begin
          // Rising select ends the command and drops every driver.
          st_d.fsm      = flash_bus_pkg::ST_DESEL;
          st_d.io_oe    = flash_bus_pkg::OE_NONE;
          st_d.selected = 1'b0;
          st_d.cmd_end  = 1'b1;
          st_d.standby  = ~busy_in;
        end
        else if (~hold_n & ~pins_s.sck)
        begin
          // Pause begins once its pin and the clock are both low.
          st_d.fsm    = flash_bus_pkg::ST_PAUSE;
          st_d.paused = 1'b1;
          st_d.io_oe  = flash_bus_pkg::OE_NONE;
        end
        else
        begin
          if (sck_rise)
          begin
            // Lane order puts the highest lane in the most significant bit.
            unique case (rx_width_in)
              flash_bus_pkg::WIDTH_TWO:  st_d.rx_sh = {st_q.rx_sh[5:0], pins_s.io[1:0]};
              flash_bus_pkg::WIDTH_FOUR: st_d.rx_sh = {st_q.rx_sh[3:0], pins_s.io};
              default:                   st_d.rx_sh = {st_q.rx_sh[6:0], pins_s.io[0]};
            endcase
            st_d.rx_cnt = st_q.rx_cnt + lane_bits(rx_width_in);
            if (st_d.rx_cnt >= 4'(flash_bus_pkg::BYTE_BITS))
            begin
              st_d.rx_cnt   = 4'h0;
              st_d.rx_byte  = st_d.rx_sh;
              st_d.rx_valid = 1'b1;
            end
          end
          if (sck_fall)
          begin
            if (tx_enable_in)
            begin
              // Drivers turn on only after a fall, once the host has let go.
              st_d.io_oe = lane_oe(tx_width_in);
              unique case (tx_width_in)
                flash_bus_pkg::WIDTH_TWO:  st_d.io_o = {2'h0, tx_word[7:6]};
                flash_bus_pkg::WIDTH_FOUR: st_d.io_o = tx_word[7:4];
                default:                   st_d.io_o = {2'h0, tx_word[7], 1'b0};
              endcase
              st_d.tx_sh  = tx_word << lane_bits(tx_width_in);
              st_d.tx_req = (st_q.tx_cnt == 4'h0);
              st_d.tx_cnt = ((st_q.tx_cnt == 4'h0) ? 4'(flash_bus_pkg::BYTE_BITS)
                             : st_q.tx_cnt) - lane_bits(tx_width_in);
            end
            else
            begin
              st_d.io_oe  = flash_bus_pkg::OE_NONE;
              st_d.tx_cnt = 4'h0;
            end
          end
        end
      end
      // Paused: the shifters freeze and the lines float.
      flash_bus_pkg::ST_PAUSE:
      begin
        st_d.io_oe = flash_bus_pkg::OE_NONE;
        if (pins_s.cs_n)
        begin
          st_d.fsm      = flash_bus_pkg::ST_DESEL;
          st_d.selected = 1'b0;
          st_d.paused   = 1'b0;
          st_d.cmd_end  = 1'b1;
          st_d.standby  = ~busy_in;
        end
        else if (hold_n & ~pins_s.sck)
        begin
          // Resume, like entry, waits for the clock to be low.
          st_d.fsm    = flash_bus_pkg::ST_ACTIVE;
          st_d.paused = 1'b0;
        end
      end
      default:
      begin
        st_d.fsm   = flash_bus_pkg::ST_DESEL;
        st_d.io_oe = flash_bus_pkg::OE_NONE;
      end
    endcase
  end

  // State register; reset leaves the interface unarmed and quiet.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      st_q           <= '0;
      st_q.fsm       <= flash_bus_pkg::ST_UNARMED;
      st_q.cs_n_prev <= 1'b0; // A select held low through reset is not a fall.
      st_q.standby   <= 1'b1;
      st_q.wp_n      <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Every output is a field of the state register.
  assign io_out              = st_q.io_o;
  assign io_oe_out           = st_q.io_oe;
  assign rx_byte_out         = st_q.rx_byte;
  assign rx_valid_out        = st_q.rx_valid;
  assign tx_req_out          = st_q.tx_req;
  assign cmd_start_out       = st_q.cmd_start;
  assign cmd_end_out         = st_q.cmd_end;
  assign selected_out        = st_q.selected;
  assign paused_out          = st_q.paused;
  assign standby_out         = st_q.standby;
  assign write_protect_n_out = st_q.wp_n;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);

  // Select seen falling while the state is unarmed or deselected.
  sequence s_select_fall;
    cs_fall && (st_q.fsm inside {flash_bus_pkg::ST_UNARMED, flash_bus_pkg::ST_DESEL});
  endsequence

  sequence s_pause_request;
    (st_q.fsm == flash_bus_pkg::ST_ACTIVE) && !pins_s.cs_n && !hold_n && !pins_s.sck;
  endsequence

  a_float_when_desel: assert property (pins_s.cs_n |=> io_oe_out == 4'h0)
    else $error("Lines driven while deselected.");
  a_standby_busy: assert property (pins_s.cs_n && busy_in && !cs_fall |=> !standby_out)
    else $error("Standby entered while busy.");
  a_select_starts: assert property (s_select_fall |=> selected_out && cmd_start_out
                                    ##1 !cmd_start_out)
    else $error("Select fall did not start a command.");
  a_unarmed_waits: assert property ((st_q.fsm == flash_bus_pkg::ST_UNARMED) && !cs_fall
                                    |=> !selected_out)
    else $error("Selected without a select fall.");
  a_capture_on_rise: assert property (!sck_rise |=> $stable(st_q.rx_sh))
    else $error("Input shifted without a clock rise.");
  a_drive_after_fall: assert property ($changed(io_out) |-> $past(sck_fall))
    else $error("Output changed without a clock fall.");
  a_pause_entry: assert property (s_pause_request |=> paused_out && io_oe_out == 4'h0)
    else $error("Pause not entered with clock low.");
  a_pause_freeze: assert property (paused_out |=> $stable(st_q.rx_cnt))
    else $error("Input taken while paused.");
  a_lane_masks: assert property (io_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("Illegal lane enable mask.");
  a_protect_off_quad: assert property (four_bit_enable_in |=> write_protect_n_out)
    else $error("Write protect active in four-bit mode.");

endmodule

// ### sim/flash_host.sv
`timescale 1ns/10ps

// Host controller model: drives serial clock, select and lanes bit by bit.
module flash_host (
  input  wire logic       mclk_in,
  input  wire logic [3:0] io_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic [3:0]      io_out,
  output logic [3:0]      io_oe_out
);
  // Select starts low at power-up, so the device has seen no fall yet.
  initial
  begin
    sck_out   = 1'b0;
    cs_n_out  = 1'b0;
    io_out    = 4'h0;
    io_oe_out = 4'h0;
  end

  // Half a serial clock period, 80 ns.
  task automatic half();
    repeat (4) @(negedge mclk_in);
  endtask

  // Clock low for half a period.
  task automatic low();
    sck_out = 1'b0;
    half();
  endtask

  // Select with the clock idling low (mode 0) or high (mode 3).
  task automatic sel(input logic idle);
    cs_n_out = 1'b1;
    sck_out  = idle;
    half();
    cs_n_out = 1'b0;
    half();
  endtask

  // Release the lanes first, then raise select.
  task automatic desel();
    half();
    io_oe_out = 4'h0;
    cs_n_out  = 1'b1;
    half();
  endtask

  // Each beat: fall, set lanes, rise, sample. MSB first, top lane highest.
  task automatic beats(input int n, input int w, input logic [7:0] d,
                       input logic drv, output logic [7:0] q);
    logic [7:0] s;
    q = 8'h00;
    s = d;
    for (int k = 0; k < n; k++)
    begin
      sck_out   = 1'b0;
      io_oe_out = drv ? 4'((1 << w) - 1) : 4'h0;
      io_out    = 4'(s >> (8 - w));
      s         = s << w;
      half();
      sck_out = 1'b1;
      q = (q << w) | 8'(w == 1 ? {3'h0, io_in[1]} : io_in & 4'((1 << w) - 1));
      half();
    end
  endtask
endmodule

// ### sim/multi_io_serial_flash_bus_interface_test.sv
`timescale 1ns/10ps

// Bench for the flash bus front end, with the host model on the pins.
module multi_io_serial_flash_bus_interface_test;
  logic                       mclk_in = 1'b0;
  logic                       reset_in = 1'b1;
  logic                       sck_in;
  logic                       cs_n_in;
  logic [3:0]                 io_in;
  logic [3:0]                 io_out;
  logic [3:0]                 io_oe_out;
  logic [3:0]                 h_out;
  logic [3:0]                 h_oe;
  logic                       four_bit_enable_in = 1'b0;
  logic                       busy_in = 1'b0;
  flash_bus_pkg::lane_width_t rx_width_in = flash_bus_pkg::WIDTH_ONE;
  flash_bus_pkg::lane_width_t tx_width_in = flash_bus_pkg::WIDTH_ONE;
  logic                       tx_enable_in = 1'b0;
  logic [7:0]                 tx_data_in = 8'h00;
  logic [7:0]                 rx_byte_out;
  logic                       rx_valid_out;
  logic                       tx_req_out;
  logic                       cmd_start_out;
  logic                       cmd_end_out;
  logic                       selected_out;
  logic                       paused_out;
  logic                       standby_out;
  logic                       write_protect_n_out;
  logic                       pause_n = 1'b1; // Host pause pin, pulled up when high.
  logic                       wp_n = 1'b1;    // Host protect pin, pulled up when high.
  logic                       flip = 1'b0;    // Undriven lanes IO0 and IO1 toggle, so stale data never matches.
  logic [7:0]                 got = 8'h00;
  int                         num_rx = 0;
  int                         num_start = 0;
  int                         num_end = 0;
  int                         num_req = 0;    // Byte requests seen on the core side.
  int                         num_errors = 0;
  int                         comparisons = 0;

  always #10 mclk_in = ~mclk_in;

  // Wire levels from both parties; the upper lanes have pull-ups.
  assign io_in = (io_oe_out & io_out) | (~io_oe_out & h_oe & h_out)
               | (~io_oe_out & ~h_oe & {pause_n, wp_n, flip, flip});

  flash_bus_front dut (.mclk_in, .reset_in, .sck_in, .cs_n_in, .io_in, .io_out, .io_oe_out,
    .four_bit_enable_in, .busy_in, .rx_width_in, .tx_width_in, .tx_enable_in, .tx_data_in,
    .rx_byte_out, .rx_valid_out, .tx_req_out, .cmd_start_out, .cmd_end_out, .selected_out,
    .paused_out, .standby_out, .write_protect_n_out);

  flash_host host (.mclk_in(mclk_in), .io_in(io_in), .sck_out(sck_in), .cs_n_out(cs_n_in),
    .io_out(h_out), .io_oe_out(h_oe));

  // Count the pulses, since each stands for one cycle only.
  always @(posedge mclk_in)
  begin
    flip <= ~flip;
    if (rx_valid_out === 1'b1)
    begin
      num_rx <= num_rx + 1;
      got    <= rx_byte_out;
    end
    if (cmd_start_out === 1'b1)
      num_start <= num_start + 1;
    if (cmd_end_out === 1'b1)
      num_end <= num_end + 1;
    if (tx_req_out === 1'b1)
      num_req <= num_req + 1;
  end

  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok)
    begin
      $display("MISMATCH at %0t: %s", $time, m);
      num_errors++;
    end
  endtask

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Select already low at power-up: nothing may be taken.
  task automatic s_unarmed();
    logic [7:0] q;
    host.beats(8, 1, 8'hA5, 1'b1, q);
    chk(num_rx == 0 && selected_out === 1'b0, "byte taken before select fall");
    host.desel();
    chk(standby_out === 1'b1 && io_oe_out === 4'h0, "not idle when deselected");
  endtask

  // A partial byte is dropped at deselect; standby waits for busy.
  task automatic s_write();
    logic [7:0] q;
    host.sel(1'b0);
    chk(selected_out === 1'b1 && standby_out === 1'b0 && num_start == 1, "no select");
    host.beats(3, 1, 8'hFF, 1'b1, q);
    host.desel();
    host.sel(1'b0);
    host.beats(8, 1, 8'h96, 1'b1, q);
    chk(num_rx == 1 && got === 8'h96, "single bit byte wrong");
    busy_in = 1'b1;
    host.desel();
    chk(standby_out === 1'b0 && num_end == 2, "standby while busy");
    busy_in = 1'b0;
    host.half();
    chk(standby_out === 1'b1, "no standby after busy");
  endtask

  // Two-wide then four-wide input; the low IO3 nibble must not pause.
  task automatic s_quad_in();
    logic [7:0] q;
    rx_width_in = flash_bus_pkg::WIDTH_TWO;
    host.sel(1'b0);
    host.beats(4, 2, 8'h69, 1'b1, q);
    chk(got === 8'h69 && num_rx == 2, "dual byte wrong");
    host.desel();
    four_bit_enable_in = 1'b1;
    rx_width_in = flash_bus_pkg::WIDTH_FOUR;
    host.sel(1'b0);
    host.beats(2, 4, 8'h5A, 1'b1, q);
    chk(got === 8'h5A && paused_out === 1'b0, "quad byte wrong");
    host.desel();
    wp_n = 1'b0;
    host.half();
    chk(write_protect_n_out === 1'b1, "protect active in quad mode");
    four_bit_enable_in = 1'b0;
    rx_width_in = flash_bus_pkg::WIDTH_ONE;
    host.half();
    chk(write_protect_n_out === 1'b0, "protect level wrong");
    wp_n = 1'b1;
  endtask

  // Pause pin falls with clock high; clocks during the pause are ignored.
  task automatic s_pause();
    logic [7:0] q;
    host.sel(1'b0);
    host.beats(4, 1, 8'hC3, 1'b1, q);
    pause_n = 1'b0;
    host.half();
    chk(paused_out === 1'b0, "paused while clock high");
    host.low();
    chk(paused_out === 1'b1 && io_oe_out === 4'h0, "pause not entered");
    host.beats(2, 1, 8'h00, 1'b1, q);
    host.low();
    pause_n = 1'b1;
    host.half();
    chk(paused_out === 1'b0, "pause not left");
    host.beats(4, 1, 8'h30, 1'b1, q);
    chk(got === 8'hC3 && num_rx == 4, "byte broken by pause");
    host.desel();
  endtask

  // Mode 3 read: the leading fall drives the first bits.
  task automatic s_read(input int w, input logic [7:0] d);
    logic [7:0] q;
    int         r0;
    r0 = num_req;
    four_bit_enable_in = (w == 4);
    tx_width_in = w == 1 ? flash_bus_pkg::WIDTH_ONE
                : w == 2 ? flash_bus_pkg::WIDTH_TWO : flash_bus_pkg::WIDTH_FOUR;
    tx_enable_in = 1'b1;
    tx_data_in = d;
    host.sel(1'b1);
    host.beats(8 / w, w, 8'h00, 1'b0, q);
    chk(q === d, "returned byte wrong");
    chk(num_req == r0 + 1, "one byte request per returned byte expected");
    chk(io_oe_out === (w == 1 ? flash_bus_pkg::OE_SINGLE : w == 2 ? flash_bus_pkg::OE_DUAL
                       : flash_bus_pkg::OE_QUAD), "lane enables wrong");
    tx_enable_in = 1'b0;
    host.desel();
    chk(io_oe_out === 4'h0, "lanes driven after deselect");
  endtask

  initial
  begin
    repeat (3) @(negedge mclk_in);
    reset_in = 1'b0;
    host.half();
    s_unarmed();
    s_write();
    s_quad_in();
    s_pause();
    s_read(1, 8'h3C);
    s_read(2, 8'hB4);
    s_read(4, 8'hE1);
    final_report();
  end

  // The tests need about 11 us; cut a hang well beyond that.
  initial
  begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
